// File: hw/sadc_clkdiv.sv
// Converter clock divider producing a one-cycle tick
`timescale 1ns/10ps
module sadc_clkdiv #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control
    input wire logic run,
    input wire logic [W-1:0] factor_m1,
    // Tick out
    output logic tick
);
    // Cycle counter within one converter clock
    logic [W-1:0] cnt_ff;
    logic tick_ff;

    // Counts 0..factor_m1, so the tick rate is clock over one to eight
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (!run) begin
            // Held in phase while run is low
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (cnt_ff >= factor_m1) begin
            cnt_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;
endmodule

// File: hw/sadc_pkg.sv
// Constants, types and helper functions for the SAR converter sequencer
// How it works
// - Four channels, 8-bit result, sampled compare.
// - Comparator decisions set trial bits one by one.
// - Fixed single: own register, completion interrupt.
// - Fixed continuous: rotate four registers, interrupt fourth.
// - Fixed continuous runs until software stops.
// - Scan single: each selected once, interrupt end.
// - One selected scan channel equals fixed single.
// - Scan continuous: repeat, results in channel registers.
// - Start by timer, software, or input edge.
// - Upper nibble checked early against limits.
// - Inside early check: full result checked again.
// - Limit enable cleared disables limit checking.
// - DAC mode drives channel-3 register to pin.
// - Clock divided by one to eight.
// - Conversion lasts at least 3.9 us at 3.3 MHz.
// - Keeps converting in idle, completion wakes.
// - No conversions in power-down states.
package sadc_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SCAN = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_BHI = 8'h10;
    localparam logic [7:0] OFS_BLO = 8'h14;
    localparam logic [7:0] OFS_RES0 = 8'h18;
    localparam logic [7:0] OFS_RES3 = 8'h24;
    // Reset values of the limit registers
    localparam logic [7:0] BHI_RST = 8'hFF;
    localparam logic [7:0] BLO_RST = 8'h00;
    // Status and mask bit positions
    localparam int ST_DONE = 0;
    localparam int ST_BND = 1;
    localparam int ST_BUSY = 8;
    // AXI responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // Conversion timing: least time at the fastest converter clock
    localparam int CONV_NS = 3900;
    localparam int ADC_MAX_KHZ = 3300;
    localparam int CONV_TICKS = (CONV_NS * ADC_MAX_KHZ + 999999) / 1000000;
    localparam int RES_BITS = 8;
    localparam int SAMPLE_TICKS = CONV_TICKS - RES_BITS;
    localparam logic [7:0] SAR_FIRST = 8'h80;
    localparam logic [2:0] BIT_MSB = 3'h7;
    localparam logic [2:0] BIT_NIB = 3'h4;
    localparam logic [1:0] SLOT_LAST = 2'h3;
    // Conversion modes
    localparam logic [1:0] MD_FIX1 = 2'h0;
    localparam logic [1:0] MD_FIXC = 2'h1;
    localparam logic [1:0] MD_SCAN1 = 2'h2;
    localparam logic [1:0] MD_SCANC = 2'h3;
    // Start sources
    localparam logic [1:0] SRC_TIMER = 2'h0;
    localparam logic [1:0] SRC_SOFT = 2'h1;
    localparam logic [1:0] SRC_EDGE = 2'h2;
    // Control register layout, low bit last
    typedef struct packed {
        logic [2:0] div_m1;
        logic dac_mode;
        logic [1:0] chan;
        logic [1:0] src;
        logic [1:0] mode;
        logic start;
        logic en;
    } sadc_ctrl_t;
    // Signals toward the analogue front end
    typedef struct packed {
        logic [1:0] mux_sel;
        logic sample_hold;
        logic [7:0] dac_code;
        logic dac_pin_en;
    } sadc_ana_t;
    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_BITS, ST_STORE} sadc_state_t;

    // Value outside the window given by the two limits
    function automatic logic outside(logic [7:0] v, logic [7:0] hi, logic [7:0] lo);
        outside = (v > hi) || (v < lo);
    endfunction

    // Lowest selected channel at or above lo, found flag on top
    function automatic logic [2:0] next_chan(logic [3:0] m, logic [2:0] lo);
        next_chan = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i] && (3'(i) >= lo)) begin
                next_chan = {1'b1, 2'(i)};
            end
        end
    endfunction
endpackage

// File: hw/sadc_top.sv
// SAR converter sequencer with AXI4-Lite register access
`timescale 1ns/10ps
module sadc_top (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // AXI4-Lite write address and data
    input wire logic [sadc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [sadc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analogue front end
    input wire logic comp_in,
    output sadc_pkg::sadc_ana_t ana_out,
    // Start sources and power state
    input wire logic timer_trig,
    input wire logic edge_pin,
    input wire logic idle_mode,
    input wire logic power_down,
    // Events
    output logic irq,
    output logic wake
);
    // Registers seen by software
    sadc_pkg::sadc_ctrl_t ctrl_ff;
    logic [3:0] scan_ff;
    logic [1:0] stat_ff, mask_ff;
    logic [7:0] bhi_ff, blo_ff;
    logic [7:0] res_ff [4];
    // Sequencer state
    sadc_pkg::sadc_state_t state_ff;
    logic [7:0] sar_ff;
    logic [2:0] bit_ff;
    logic [3:0] cnt_ff;
    logic [1:0] ch_ff, slot_ff;
    logic early_ff;
    // Pin synchronisers and filtered levels
    logic [2:0] cmp_s_ff, edg_s_ff;
    logic cmp_ff, edg_ff, edg_d_ff;
    // Bus slave state
    logic aw_got_ff, w_got_ff, bvalid_ff, awready_ff, wready_ff;
    logic arready_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    // Outputs held in flops
    sadc_pkg::sadc_ana_t ana_ff;
    logic irq_ff, wake_ff;
    // Internal strobes
    logic tick, wr_go, start_wr, go, abort, store, done_ev, bnd_ev, keep;
    logic [7:0] resolved;
    logic [2:0] nxt;
    logic [1:0] wr_idx;

    // Converter clock tick
    sadc_clkdiv #(.W(3)) u_div (
        .clock(clock),
        .resetn(resetn),
        .run(ctrl_ff.en),
        .factor_m1(ctrl_ff.div_m1),
        .tick(tick)
    );

    // Three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmp_s_ff <= '0;
            edg_s_ff <= '0;
            cmp_ff <= 1'b0;
            edg_ff <= 1'b0;
            edg_d_ff <= 1'b0;
        end else begin
            cmp_s_ff <= {cmp_s_ff[1:0], comp_in};
            edg_s_ff <= {edg_s_ff[1:0], edge_pin};
            if (cmp_s_ff[1] == cmp_s_ff[2]) begin
                cmp_ff <= cmp_s_ff[2];
            end
            if (edg_s_ff[1] == edg_s_ff[2]) begin
                edg_ff <= edg_s_ff[2];
            end
            edg_d_ff <= edg_ff;
        end
    end

    // Start and stop conditions
    always_comb begin
        abort = !ctrl_ff.en || power_down || ctrl_ff.dac_mode;
        go = 1'b0;
        unique case (ctrl_ff.src)
            sadc_pkg::SRC_TIMER: go = timer_trig;
            sadc_pkg::SRC_SOFT: go = start_wr;
            sadc_pkg::SRC_EDGE: go = edg_ff && !edg_d_ff;
            default: go = 1'b0;
        endcase
        // An empty scan selection never starts
        if (ctrl_ff.mode[1] && (scan_ff == 4'h0)) begin
            go = 1'b0;
        end
    end

    // Comparator high keeps the trial bit: input at or above the DAC level
    always_comb begin
        keep = cmp_ff;
        resolved = keep ? sar_ff : (sar_ff & ~(8'h01 << bit_ff));
        store = (state_ff == sadc_pkg::ST_STORE);
        nxt = sadc_pkg::next_chan(scan_ff, {1'b0, ch_ff} + 3'h1);
        wr_idx = (ctrl_ff.mode == sadc_pkg::MD_FIXC) ? slot_ff : ch_ff;
        unique case (ctrl_ff.mode)
            sadc_pkg::MD_FIX1: done_ev = store;
            sadc_pkg::MD_FIXC: done_ev = store && (slot_ff == sadc_pkg::SLOT_LAST);
            default: done_ev = store && !nxt[2];
        endcase
        bnd_ev = 1'b0;
        if ((state_ff == sadc_pkg::ST_BITS) && tick && mask_ff[sadc_pkg::ST_BND]) begin
            // Early nibble check, else the full check at the last bit
            if (bit_ff == sadc_pkg::BIT_NIB) begin
                bnd_ev = sadc_pkg::outside({resolved[7:4], 4'h0}, {bhi_ff[7:4], 4'h0},
                    {blo_ff[7:4], 4'h0});
            end else if (bit_ff == 3'h0) begin
                bnd_ev = !early_ff && sadc_pkg::outside(resolved, bhi_ff, blo_ff);
            end
        end
    end

    // Sequencer: sample, eight decisions, store, then next step by mode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= sadc_pkg::ST_IDLE;
            sar_ff <= '0;
            bit_ff <= '0;
            cnt_ff <= '0;
            ch_ff <= '0;
            slot_ff <= '0;
            early_ff <= 1'b0;
        end else if (abort) begin
            // Partial results are dropped here
            state_ff <= sadc_pkg::ST_IDLE;
            slot_ff <= '0;
        end else begin
            unique case (state_ff)
                sadc_pkg::ST_IDLE: begin
                    if (go) begin
                        state_ff <= sadc_pkg::ST_SAMPLE;
                        cnt_ff <= '0;
                        early_ff <= 1'b0;
                        // Fixed modes take the chosen channel, scans the lowest one
                        ch_ff <= ctrl_ff.mode[1] ? 2'(sadc_pkg::next_chan(scan_ff, 3'h0))
                            : ctrl_ff.chan;
                    end
                end
                sadc_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'(sadc_pkg::SAMPLE_TICKS - 1)) begin
                            state_ff <= sadc_pkg::ST_BITS;
                            sar_ff <= sadc_pkg::SAR_FIRST;
                            bit_ff <= sadc_pkg::BIT_MSB;
                        end
                    end
                end
                sadc_pkg::ST_BITS: begin
                    if (tick) begin
                        if (bit_ff == 3'h0) begin
                            sar_ff <= resolved;
                            state_ff <= sadc_pkg::ST_STORE;
                        end else begin
                            sar_ff <= resolved | (8'h01 << (bit_ff - 3'h1));
                            bit_ff <= bit_ff - 3'h1;
                        end
                        if (bnd_ev) begin
                            early_ff <= 1'b1;
                        end
                    end
                end
                sadc_pkg::ST_STORE: begin
                    cnt_ff <= '0;
                    early_ff <= 1'b0;
                    state_ff <= sadc_pkg::ST_SAMPLE;
                    unique case (ctrl_ff.mode)
                        sadc_pkg::MD_FIX1: state_ff <= sadc_pkg::ST_IDLE;
                        sadc_pkg::MD_FIXC: slot_ff <= slot_ff + 2'h1;
                        sadc_pkg::MD_SCAN1: begin
                            if (nxt[2]) begin
                                ch_ff <= nxt[1:0];
                            end else begin
                                state_ff <= sadc_pkg::ST_IDLE;
                            end
                        end
                        sadc_pkg::MD_SCANC: begin
                            // Wrap to the lowest selected channel
                            ch_ff <= nxt[2] ? nxt[1:0]
                                : 2'(sadc_pkg::next_chan(scan_ff, 3'h0));
                        end
                    endcase
                end
            endcase
        end
    end

    // Bus write accepted when both address and data have arrived
    assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
    assign start_wr = wr_go && (awaddr_ff == sadc_pkg::OFS_CTRL) && wstrb_ff[0]
        && wdata_ff[1];

    // Result registers: sequencer stores, software writes channel 3 in DAC mode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                res_ff[i] <= '0;
            end
        end else if (store && !abort) begin
            res_ff[wr_idx] <= sar_ff;
        end else if (wr_go && (awaddr_ff == sadc_pkg::OFS_RES3) && wstrb_ff[0]
            && ctrl_ff.dac_mode) begin
            res_ff[3] <= wdata_ff[7:0];
        end
    end

    // Control, scan selection, mask and limits
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= '0;
            scan_ff <= '0;
            mask_ff <= '0;
            bhi_ff <= sadc_pkg::BHI_RST;
            blo_ff <= sadc_pkg::BLO_RST;
        end else if (wr_go) begin
            unique case (awaddr_ff)
                sadc_pkg::OFS_CTRL: begin
                    if (wstrb_ff[0]) begin
                        ctrl_ff[7:0] <= wdata_ff[7:0] & 8'hFD; // Start bit reads zero
                    end
                    if (wstrb_ff[1]) begin
                        ctrl_ff[11:8] <= wdata_ff[11:8];
                    end
                end
                sadc_pkg::OFS_SCAN: if (wstrb_ff[0]) scan_ff <= wdata_ff[3:0];
                sadc_pkg::OFS_MASK: if (wstrb_ff[0]) mask_ff <= wdata_ff[1:0];
                sadc_pkg::OFS_BHI: if (wstrb_ff[0]) bhi_ff <= wdata_ff[7:0];
                sadc_pkg::OFS_BLO: if (wstrb_ff[0]) blo_ff <= wdata_ff[7:0];
                default: ;
            endcase
        end
    end

    // Sticky status, cleared by writing one; a new event beats the clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stat_ff <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_go && (awaddr_ff == sadc_pkg::OFS_STAT) && wstrb_ff[0]
                    && wdata_ff[i]) begin
                    stat_ff[i] <= 1'b0;
                end
            end
            if (done_ev && !abort) begin
                stat_ff[sadc_pkg::ST_DONE] <= 1'b1;
            end
            if (bnd_ev && !abort) begin
                stat_ff[sadc_pkg::ST_BND] <= 1'b1;
            end
        end
    end

    // Interrupt, wake and analogue outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
            ana_ff <= '0;
        end else begin
            irq_ff <= |(stat_ff & mask_ff);
            wake_ff <= idle_mode && |(stat_ff & mask_ff);
            ana_ff.mux_sel <= ch_ff;
            ana_ff.sample_hold <= (state_ff == sadc_pkg::ST_SAMPLE);
            // The DAC follows the trial code, or the stored value in DAC mode
            ana_ff.dac_code <= ctrl_ff.dac_mode ? res_ff[3] : sar_ff;
            ana_ff.dac_pin_en <= ctrl_ff.dac_mode && !power_down;
        end
    end

    // Write channels: address and data taken in either order
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= sadc_pkg::RESP_OK;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awaddr_ff <= s_axi_awaddr;
                aw_got_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_got_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                // Only word-aligned offsets inside the map are accepted
                bresp_ff <= (awaddr_ff <= sadc_pkg::OFS_RES3 && awaddr_ff[1:0] == 2'h0)
                    ? sadc_pkg::RESP_OK : sadc_pkg::RESP_ERR;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= sadc_pkg::RESP_OK;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= sadc_pkg::RESP_OK;
            unique case (s_axi_araddr)
                sadc_pkg::OFS_CTRL: rdata_ff <= 32'(ctrl_ff);
                sadc_pkg::OFS_SCAN: rdata_ff <= 32'(scan_ff);
                sadc_pkg::OFS_STAT: rdata_ff <= 32'(stat_ff)
                    | (32'(state_ff != sadc_pkg::ST_IDLE) << sadc_pkg::ST_BUSY);
                sadc_pkg::OFS_MASK: rdata_ff <= 32'(mask_ff);
                sadc_pkg::OFS_BHI: rdata_ff <= 32'(bhi_ff);
                sadc_pkg::OFS_BLO: rdata_ff <= 32'(blo_ff);
                8'h18, 8'h1C, 8'h20, 8'h24: begin
                    rdata_ff <= 32'(res_ff[2'((s_axi_araddr - sadc_pkg::OFS_RES0) >> 2)]);
                end
                default: begin
                    rdata_ff <= '0;
                    rresp_ff <= sadc_pkg::RESP_ERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // Port drive
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign ana_out = ana_ff;
    assign irq = irq_ff;
    assign wake = wake_ff;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Ticks since sampling began, for the conversion length check
    logic [4:0] conv_ticks_ff;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            conv_ticks_ff <= '0;
        end else if (state_ff == sadc_pkg::ST_IDLE || store) begin
            conv_ticks_ff <= '0;
        end else if (tick && conv_ticks_ff != 5'h1F) begin
            conv_ticks_ff <= conv_ticks_ff + 5'h1;
        end
    end
    sequence s_sample_end;
        state_ff == sadc_pkg::ST_SAMPLE ##1 state_ff == sadc_pkg::ST_BITS;
    endsequence
    a_conv_min_len: assert property (store |-> conv_ticks_ff >= 5'(sadc_pkg::CONV_TICKS))
        else $error("conversion shorter than minimum");
    a_sar_first_trial: assert property (s_sample_end |-> sar_ff == sadc_pkg::SAR_FIRST)
        else $error("first trial code wrong");
    a_disable_idle: assert property (!ctrl_ff.en |=> state_ff == sadc_pkg::ST_IDLE)
        else $error("sequencer running while disabled");
    a_pdown_idle: assert property (power_down |=> state_ff == sadc_pkg::ST_IDLE)
        else $error("conversion during power-down");
    a_bnd_off: assert property (!mask_ff[sadc_pkg::ST_BND]
        |=> !$rose(stat_ff[sadc_pkg::ST_BND]))
        else $error("limit flag while checking disabled");
    a_fix1_stop: assert property (store && ctrl_ff.mode == sadc_pkg::MD_FIX1 && !abort
        |=> state_ff == sadc_pkg::ST_IDLE && stat_ff[0])
        else $error("single conversion did not finish");
    a_rotate_slot: assert property (store && ctrl_ff.mode == sadc_pkg::MD_FIXC && !abort
        |=> slot_ff == $past(slot_ff) + 2'h1)
        else $error("result slot did not advance");
    a_wake_idle: assert property (idle_mode && |(stat_ff & mask_ff) |=> wake)
        else $error("no wake on completion in idle");
    a_dac_follow: assert property (ctrl_ff.dac_mode ##1 ctrl_ff.dac_mode
        |-> ana_out.dac_code == $past(res_ff[3]))
        else $error("DAC code not from channel 3 register");
endmodule

// File: test/sadc_ana_model.sv
// Behavioural comparator standing at the converter's analogue side
`timescale 1ns/10ps
module sadc_ana_model #(
    parameter logic [31:0] VIN = 32'h115AC400
) (
    // Analogue front end
    input wire sadc_pkg::sadc_ana_t ana_out,
    output logic comp_in
);
    // Level seen by the channel mux
    logic [7:0] level;
    // Comparator high while the selected input is at or above the trial code
    always_comb begin
        level = VIN[{ana_out.mux_sel, 3'h0} +: 8];
        comp_in = (level >= ana_out.dac_code);
    end
endmodule

// File: test/sar_adc_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module sar_adc_sequencer_bench;
    logic clock = 1'b0, resetn = 1'b0, comp_in, irq, wake, idle_mode = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic timer_trig = 1'b0, edge_pin = 1'b0, power_down = 1'b0;
    sadc_pkg::sadc_ana_t ana_out;
    int num_errors = 0, num_checks = 0;
    sadc_top sadc_top_inst (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comp_in(comp_in), .ana_out(ana_out), .timer_trig(timer_trig),
        .edge_pin(edge_pin), .idle_mode(idle_mode), .power_down(power_down), .irq(irq),
        .wake(wake));
    sadc_ana_model sadc_ana_model_inst (.ana_out(ana_out), .comp_in(comp_in));
    // 40 MHz clock
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Compare one value, report mismatch in hex
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // AXI4-Lite write; channels released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ap, wp;
        ap = 1;
        wp = 1;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (ap || wp) begin
            @(posedge clock);
            if (ap && awready === 1'b1) begin ap = 0; awvalid <= 0; end
            if (wp && wready === 1'b1) begin wp = 0; wvalid <= 0; end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 0;
        chk(32'(bresp), 32'(er));
    endtask
    // AXI4-Lite read; data taken at the rvalid edge
    task automatic rdr(input logic [7:0] a, input logic [1:0] er);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge clock);
        rd = rdata;
        rready <= 0;
        chk(32'(rresp), 32'(er));
        @(posedge clock);
    endtask
    // Start one conversion and poll for a status bit
    task automatic conv(input logic [31:0] ctrl, input int bitn);
        // Enable and source first: the start bit acts on the source already stored
        wr(sadc_pkg::OFS_CTRL, ctrl & 32'hFFFFFFFD, sadc_pkg::RESP_OK);
        wr(sadc_pkg::OFS_CTRL, ctrl, sadc_pkg::RESP_OK);
        rd = 32'h0;
        for (int i = 0; i < 200 && rd[bitn] !== 1'b1; i++) rdr(sadc_pkg::OFS_STAT, 2'h0);
        chk(32'(rd[bitn]), 32'h1);
    endtask
    // Reset values and refused accesses
    task automatic t_regs();
        rdr(sadc_pkg::OFS_BHI, sadc_pkg::RESP_OK);
        chk(rd, 32'h000000FF);
        rdr(8'h28, sadc_pkg::RESP_ERR);
        chk(rd, 32'h0);
        wr(8'h28, 32'h1, sadc_pkg::RESP_ERR);
    endtask
    // Fixed single on channel 2, completion interrupt and wake in idle
    task automatic t_single();
        idle_mode <= 1;
        wr(sadc_pkg::OFS_MASK, 32'h1, sadc_pkg::RESP_OK);
        conv(32'h00000E93, sadc_pkg::ST_DONE);
        rdr(8'h20, sadc_pkg::RESP_OK);
        chk(rd, 32'h0000005A);
        chk(32'({irq, wake}), 32'h3);
        wr(sadc_pkg::OFS_STAT, 32'h1, sadc_pkg::RESP_OK);
        @(posedge clock);
        chk(32'({irq, wake}), 32'h0);
        idle_mode <= 0;
    endtask
    // Early nibble above the high limit on channel 1
    task automatic t_limit();
        wr(sadc_pkg::OFS_BHI, 32'h30, sadc_pkg::RESP_OK);
        wr(sadc_pkg::OFS_MASK, 32'h2, sadc_pkg::RESP_OK);
        conv(32'h00000E53, sadc_pkg::ST_DONE);
        chk(rd, 32'h00000003);
        rdr(8'h1C, sadc_pkg::RESP_OK);
        chk(rd, 32'h000000C4);
        chk(32'(irq), 32'h1);
        wr(sadc_pkg::OFS_STAT, 32'h3, sadc_pkg::RESP_OK);
    endtask
    // DAC mode: channel-3 register feeds the DAC code and enables the pin
    task automatic t_dac();
        wr(sadc_pkg::OFS_CTRL, 32'h00000101, sadc_pkg::RESP_OK);
        wr(sadc_pkg::OFS_RES3, 32'hA5, sadc_pkg::RESP_OK);
        rdr(sadc_pkg::OFS_RES3, sadc_pkg::RESP_OK);
        chk(rd, 32'h000000A5);
        chk(32'({ana_out.dac_code, ana_out.dac_pin_en}), 32'h0000014B);
    endtask
    // Scan single over channels 0 and 3, done only after the last
    task automatic t_scan();
        wr(sadc_pkg::OFS_SCAN, 32'h9, sadc_pkg::RESP_OK);
        conv(32'h00000E1B, sadc_pkg::ST_DONE);
        chk(rd, 32'h00000001);
        rdr(sadc_pkg::OFS_RES3, sadc_pkg::RESP_OK);
        chk(rd, 32'h00000011);
        wr(sadc_pkg::OFS_STAT, 32'h3, sadc_pkg::RESP_OK);
    endtask
    // Power-down blocks a soft start; edge and timer starts on channel 3
    task automatic t_starts();
        power_down <= 1;
        wr(sadc_pkg::OFS_CTRL, 32'h00000ED3, sadc_pkg::RESP_OK);
        repeat (150) @(posedge clock);
        rdr(sadc_pkg::OFS_STAT, sadc_pkg::RESP_OK);
        chk(rd, 32'h0);
        power_down <= 0;
        wr(sadc_pkg::OFS_CTRL, 32'h00000EE1, sadc_pkg::RESP_OK);
        edge_pin <= 1;
        conv(32'h00000EE1, sadc_pkg::ST_DONE);
        wr(sadc_pkg::OFS_STAT, 32'h3, sadc_pkg::RESP_OK);
        wr(sadc_pkg::OFS_CTRL, 32'h00000EC1, sadc_pkg::RESP_OK);
        timer_trig <= 1;
        @(posedge clock);
        timer_trig <= 0;
        conv(32'h00000EC1, sadc_pkg::ST_DONE);
        edge_pin <= 0;
    endtask
    // Verdict
    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        t_regs();
        t_single();
        t_limit();
        t_dac();
        t_scan();
        t_starts();
        complete_run();
    end
endmodule
